/* verilog/drop_report_cfg.svh */
// register offsets, field positions, reset values and codes of the drop reporter
`ifndef DROP_REPORT_CFG_SVH
`define DROP_REPORT_CFG_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define IDX_RATE_DROP_CNT 14'h1c18
`define IDX_DROP_INT_MASK 14'h1c20
`define IDX_DROP_INT_PEND 14'h1c21
`define ADDR_RATE_DROP_CNT 16'h7060
`define ADDR_DROP_INT_MASK 16'h7080
`define ADDR_DROP_INT_PEND 16'h7084
`define ADDR_IRQ_STAT 16'h7090
`define ADDR_IRQ_EN 16'h7094
`define ADDR_IRQ_CLR 16'h7098

// ****************************************
// field positions and reset values
// ****************************************
`define MASK_BIT 0
`define MASK_RESET 1'h1
`define CNT_RESET 32'h0000_0000
`define CNT_MAX 32'hffff_ffff
`define SLOT_B_REASON_LSB 10
`define SLOT_B_PORT_LSB 8
`define SLOT_B_VALID_BIT 7
`define SLOT_A_REASON_LSB 3
`define SLOT_A_PORT_LSB 1
`define SLOT_A_VALID_BIT 0

// ****************************************
// drop reason and port codes
// ****************************************
`define RSN_BCAST_LEVEL 4'h0
`define RSN_RED 4'h1
`define RSN_NO_BUFFER 4'h2
`define RSN_NO_DESC 4'h3
`define RSN_NO_DEST 4'h4
`define RSN_RX_ERROR 4'h5
`define RSN_DROP_LEVEL 4'h6
`define RSN_YELLOW 4'h9
`define PORT_HOST 2'h0
`define PORT_ONE 2'h1
`define PORT_TWO 2'h2

`endif

/* verilog/drop_report_pkg.sv */
// types shared by the drop event reporter
package drop_report_pkg;

    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic [3:0] reason;
    } drop_slot_t;

    typedef struct packed {
        logic valid;
        logic [3:0] reason;
        logic [1:0] port;
    } drop_event_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

/* verilog/drop_event_filter.sv */
// checks an incoming drop event and passes only reportable codes
`timescale 1ns/100ps
`default_nettype none
`include "drop_report_cfg.svh"

module drop_event_filter (
    // incoming event
    input wire drop_report_pkg::drop_event_t event_in,
    // checked event
    output logic legal_out
);

    logic code_ok;
    logic port_ok;

    // reserved codes are never recorded, so a slot never reports them
    always_comb begin
        unique case (event_in.reason)
            `RSN_BCAST_LEVEL, `RSN_RED, `RSN_NO_BUFFER, `RSN_NO_DESC,
            `RSN_NO_DEST, `RSN_RX_ERROR, `RSN_DROP_LEVEL,
            `RSN_YELLOW: code_ok = 1'b1; // [R9] [R10] [R11]
            default: code_ok = 1'b0; // [R11]
        endcase
    end

    assign port_ok = (event_in.port != 2'h3); // [R12]
    assign legal_out = event_in.valid && code_ok && port_ok;

endmodule
`default_nettype wire

/* verilog/drop_event_reporter.sv */
// port 2 rate drop counter, drop interrupt mask and two-slot pending status
//
// Overview of operation
// R1: count port 2 ingress rate-limit drops
// R2: read returns count, then clears it
// R3: counter saturates at all ones
// R4: mask bit 0 resets set, blocks interrupt
// R5: mask gates interrupt only, not capture
// R6: two independent drop status slots
// R7: slot B reason 13:10, port 9:8, valid 7
// R8: slot A reason 6:3, port 2:1, valid 0
// R9: reason codes zero to three defined
// R10: reason codes four to six defined
// R11: code nine yellow; others reserved, unreported
// R12: port codes host, one, two; three reserved
// R13: slot A shares slot B reason codes
// R14: pending fields reset and clear on read
// R15: fill slot A first, then B, else drop
// R16: interrupt while valid slot and unmasked
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "drop_report_cfg.svh"

module drop_event_reporter (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // buffer manager events
    input wire logic rate_drop_p2_in,
    input wire logic drop_valid_in,
    input wire logic [3:0] drop_reason_in,
    input wire logic [1:0] drop_port_in,
    // interrupt
    output logic irq_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] count;
        logic mask;
        drop_report_pkg::drop_slot_t slot_a;
        drop_report_pkg::drop_slot_t slot_b;
        logic [31:0] rdata;
        logic irq;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
    } state_t;

    state_t st;
    state_t next_st;
    drop_report_pkg::drop_event_t ev;
    drop_report_pkg::reg_req_t req;
    logic ev_legal;
    logic rd_cnt;
    logic rd_pend;
    logic wr_mask;
    logic [2:0] ev_bits;

    assign ev = '{valid: drop_valid_in, reason: drop_reason_in,
                  port: drop_port_in};
    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in,
                   wr: reg_wr_in, rd: reg_rd_in};

    drop_event_filter u_filter (
        .event_in(ev),
        .legal_out(ev_legal)
    );

    assign rd_cnt = req.rd && (req.addr == `ADDR_RATE_DROP_CNT);
    assign rd_pend = req.rd && (req.addr == `ADDR_DROP_INT_PEND);
    assign wr_mask = req.wr && (req.addr == `ADDR_DROP_INT_MASK);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        // counter: clear on read, but a drop in the same cycle counts
        if (rd_cnt) begin
            next_st.count = 32'h0; // [R2]
        end
        if (rate_drop_p2_in) begin
            if (rd_cnt) begin
                next_st.count = 32'h1; // [R1]
            end else if (st.count != `CNT_MAX) begin
                next_st.count = st.count + 32'h1; // [R1]
            end // [R3]
        end
        if (wr_mask) begin
            next_st.mask = req.wdata[`MASK_BIT]; // [R4]
        end
        // pending read clears both slots; a new event lands in empty slot A
        if (rd_pend) begin
            next_st.slot_a = '0; // [R14]
            next_st.slot_b = '0; // [R14]
        end
        // capture is independent of the mask
        if (ev_legal) begin // [R5]
            if (!st.slot_a.valid || rd_pend) begin
                next_st.slot_a = '{valid: 1'b1, port: ev.port,
                                   reason: ev.reason}; // [R15] [R6]
            end else if (!st.slot_b.valid) begin
                next_st.slot_b = '{valid: 1'b1, port: ev.port,
                                   reason: ev.reason}; // [R15] [R6]
            end
        end
        // side status: 0 count event, 1 legal event, 2 slot overflow
        ev_bits[0] = rate_drop_p2_in;
        ev_bits[1] = ev_legal;
        ev_bits[2] = ev_legal && st.slot_a.valid && st.slot_b.valid
                     && !rd_pend;
        if (req.wr && req.addr == `ADDR_IRQ_CLR) begin
            next_st.irq_stat = st.irq_stat & ~req.wdata[2:0];
        end
        if (req.wr && req.addr == `ADDR_IRQ_EN) begin
            next_st.irq_en = req.wdata[2:0];
        end
        next_st.irq_stat = next_st.irq_stat | ev_bits;
        // read data
        next_st.rdata = 32'h0;
        if (req.rd) begin
            unique case (req.addr)
                `ADDR_RATE_DROP_CNT: next_st.rdata = st.count; // [R2]
                `ADDR_DROP_INT_MASK: next_st.rdata = {31'h0, st.mask};
                `ADDR_DROP_INT_PEND: next_st.rdata = {18'h0,
                    st.slot_b.reason, st.slot_b.port, st.slot_b.valid,
                    st.slot_a.reason, st.slot_a.port,
                    st.slot_a.valid}; // [R7] [R8] [R13]
                `ADDR_IRQ_STAT: next_st.rdata = {29'h0, st.irq_stat};
                `ADDR_IRQ_EN: next_st.rdata = {29'h0, st.irq_en};
                default: next_st.rdata = 32'h0;
            endcase
        end
        // interrupt follows the state being registered; the one mask bit
        // silences the side status too, so software has a single off switch
        next_st.irq = !next_st.mask // [R16] [R4]
                      && (next_st.slot_a.valid || next_st.slot_b.valid
                          || |(next_st.irq_stat & next_st.irq_en));
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st.count <= `CNT_RESET; // [R2]
            st.mask <= `MASK_RESET; // [R4]
            st.slot_a <= '0; // [R14]
            st.slot_b <= '0; // [R14]
            st.rdata <= 32'h0;
            st.irq <= 1'b0;
            st.irq_stat <= 3'h0;
            st.irq_en <= 3'h0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign irq_out = st.irq;

    // ****************************************
    // checks
    // ****************************************
    sequence s_cnt_read;
        rd_cnt && !rate_drop_p2_in;
    endsequence

    sequence s_cnt_zero;
        st.count == 32'h0;
    endsequence

    a_count_increment: assert property (@(posedge clk_in) // [R1]
        disable iff (sys_rst_in)
        rate_drop_p2_in && !rd_cnt && st.count != `CNT_MAX
        |=> st.count == $past(st.count) + 32'h1)
        else $error("counter did not increment on drop");

    a_read_clears: assert property (@(posedge clk_in) // [R2]
        disable iff (sys_rst_in)
        s_cnt_read |=> s_cnt_zero ##0 reg_rdata_out == $past(st.count))
        else $error("count read did not return value and clear");

    a_count_saturate: assert property (@(posedge clk_in) // [R3]
        disable iff (sys_rst_in)
        st.count == `CNT_MAX && !rd_cnt |=> st.count == `CNT_MAX)
        else $error("counter wrapped");

    a_mask_blocks: assert property (@(posedge clk_in) // [R4]
        disable iff (sys_rst_in)
        st.mask |-> !irq_out)
        else $error("interrupt raised while masked");

    a_capture_masked: assert property (@(posedge clk_in) // [R5]
        disable iff (sys_rst_in)
        ev_legal && !st.slot_a.valid |=> st.slot_a.valid)
        else $error("event not captured in empty slot a");

    a_fill_b_second: assert property (@(posedge clk_in) // [R15]
        disable iff (sys_rst_in)
        ev_legal && st.slot_a.valid && !st.slot_b.valid && !rd_pend
        |=> st.slot_b.valid && st.slot_b.reason == $past(ev.reason))
        else $error("second event not placed in slot b");

    a_pend_clear: assert property (@(posedge clk_in) // [R14]
        disable iff (sys_rst_in)
        rd_pend && !ev_legal |=> !st.slot_a.valid && !st.slot_b.valid)
        else $error("pending not cleared on read");

    a_no_reserved: assert property (@(posedge clk_in) // [R11]
        disable iff (sys_rst_in)
        st.slot_a.valid |-> st.slot_a.reason != 4'h7
        && st.slot_a.reason < 4'ha && st.slot_a.reason != 4'h8)
        else $error("reserved reason reported");

    a_irq_pending: assert property (@(posedge clk_in) // [R16]
        disable iff (sys_rst_in)
        st.slot_a.valid && !st.mask |-> irq_out)
        else $error("interrupt missing with unmasked pending");

    sequence s_both_full;
        ev_legal && st.slot_a.valid && st.slot_b.valid && !rd_pend;
    endsequence

    sequence s_slots_held;
        $stable(st.slot_a) && $stable(st.slot_b);
    endsequence

    a_reset_state: assert property (@(posedge clk_in) // [R2] [R4] [R14]
        $past(sys_rst_in) && !sys_rst_in
        |-> st.count == `CNT_RESET && st.mask == `MASK_RESET
        && st.slot_a == '0 && st.slot_b == '0 && !irq_out)
        else $error("state after reset not at reset values");

    a_count_hold: assert property (@(posedge clk_in) // [R1]
        disable iff (sys_rst_in)
        !rate_drop_p2_in && !rd_cnt |=> $stable(st.count))
        else $error("counter moved without a drop or read");

    a_read_drop_one: assert property (@(posedge clk_in) // [R2]
        disable iff (sys_rst_in)
        rd_cnt && rate_drop_p2_in |=> st.count == 32'h1)
        else $error("drop beside a count read was lost");

    a_mask_write: assert property (@(posedge clk_in) // [R4]
        disable iff (sys_rst_in)
        wr_mask |=> st.mask == $past(req.wdata[`MASK_BIT]))
        else $error("mask write did not land");

    a_slot_a_fields: assert property (@(posedge clk_in) // [R8] [R15]
        disable iff (sys_rst_in)
        ev_legal && (!st.slot_a.valid || rd_pend)
        |=> st.slot_a.reason == $past(ev.reason)
        && st.slot_a.port == $past(ev.port))
        else $error("slot a fields differ from event");

    a_slot_b_port: assert property (@(posedge clk_in) // [R7] [R15]
        disable iff (sys_rst_in)
        ev_legal && st.slot_a.valid && !st.slot_b.valid && !rd_pend
        |=> st.slot_b.port == $past(ev.port))
        else $error("slot b port differs from event");

    a_full_drops: assert property (@(posedge clk_in) // [R6] [R15]
        disable iff (sys_rst_in)
        s_both_full |=> s_slots_held)
        else $error("full slots overwritten by a third event");

    a_read_refill: assert property (@(posedge clk_in) // [R14] [R15]
        disable iff (sys_rst_in)
        rd_pend && ev_legal |=> st.slot_a.valid && !st.slot_b.valid)
        else $error("event beside pending read not in slot a");

    a_pend_layout: assert property (@(posedge clk_in) // [R7] [R8]
        disable iff (sys_rst_in)
        rd_pend |=> reg_rdata_out == {18'h0, $past(st.slot_b.reason),
        $past(st.slot_b.port), $past(st.slot_b.valid),
        $past(st.slot_a.reason), $past(st.slot_a.port),
        $past(st.slot_a.valid)})
        else $error("pending read data out of place");

    a_no_bad_port: assert property (@(posedge clk_in) // [R12]
        disable iff (sys_rst_in)
        (!st.slot_a.valid || st.slot_a.port != 2'h3)
        && (!st.slot_b.valid || st.slot_b.port != 2'h3))
        else $error("reserved port reported");

    a_b_no_reserved: assert property (@(posedge clk_in) // [R11] [R13]
        disable iff (sys_rst_in)
        st.slot_b.valid |-> st.slot_b.reason inside {[4'h0:4'h6], 4'h9})
        else $error("reserved reason reported in slot b");

    a_irq_either: assert property (@(posedge clk_in) // [R16]
        disable iff (sys_rst_in)
        (st.slot_a.valid || st.slot_b.valid) && !st.mask |-> irq_out)
        else $error("interrupt missing with a pending slot");

    a_irq_cause: assert property (@(posedge clk_in) // [R4] [R16]
        disable iff (sys_rst_in)
        irq_out |-> !st.mask && (st.slot_a.valid || st.slot_b.valid
        || |(st.irq_stat & st.irq_en)))
        else $error("interrupt without an unmasked cause");

    a_rdata_idle: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        !req.rd |=> reg_rdata_out == 32'h0)
        else $error("read data stood outside the read answer");

    a_status_sticky: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ev_legal |=> st.irq_stat[1])
        else $error("capture status not set");

endmodule
`default_nettype wire

/* dv/switch_drop_event_reporter_tb_top.sv */
// self-checking bench of the drop event reporter
`timescale 1ns/100ps
`default_nettype none
`include "drop_report_cfg.svh"

module switch_drop_event_reporter_tb_top;
    // ****************************************
    // stimulus, model state and bookkeeping
    // ****************************************
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic rate_drop_p2_in = 1'b0;
    logic drop_valid_in = 1'b0;
    logic [3:0] drop_reason_in = 4'h0;
    logic [1:0] drop_port_in = 2'h0;
    logic irq_out;
    integer seed = 32'h2ae8;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    logic b;
    logic [1:0] p;
    logic [6:0] slot_a = 7'h00;
    logic [6:0] slot_b = 7'h00;
    logic [31:0] got;
    logic [3:0] legal [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};

    always #4 clk_in = ~clk_in;

    drop_event_reporter u_drop_event_reporter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .rate_drop_p2_in(rate_drop_p2_in),
        .drop_valid_in(drop_valid_in),
        .drop_reason_in(drop_reason_in),
        .drop_port_in(drop_port_in),
        .irq_out(irq_out)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // a trailing edge keeps the strobe from being raised in the same step
    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_in);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
        @(posedge clk_in);
    endtask

    task automatic irq_check(input logic e);
        repeat (2) @(posedge clk_in);
        #1 check("irq", {31'h0, irq_out}, {31'h0, e});
        @(posedge clk_in);
    endtask

    // caller lowers the valid so events may follow back to back
    task automatic drop_event(input logic [3:0] r, input logic [1:0] q);
        drop_valid_in <= 1'b1;
        drop_reason_in <= r;
        drop_port_in <= q;
        if (r inside {[4'h0:4'h6], 4'h9} && q != 2'h3) begin
            if (!slot_a[0]) slot_a = {r, q, 1'b1};
            else if (!slot_b[0]) slot_b = {r, q, 1'b1};
        end
        @(posedge clk_in);
    endtask

    function automatic logic [31:0] pend_exp();
        return {18'h0, slot_b, slot_a};
    endfunction

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        reg_read(`ADDR_RATE_DROP_CNT, got);
        check("count reset", got, `CNT_RESET);
        reg_read(`ADDR_DROP_INT_MASK, got);
        check("mask reset", got, 32'h0000_0001);
        reg_read(`ADDR_DROP_INT_PEND, got);
        check("pending reset", got, 32'h0000_0000);
        irq_check(1'b0);
        reg_write(16'h7000, $random(seed));
        reg_read(16'h7000, got);
        check("unmapped", got, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            repeat (40) begin
                b = 1'($random(seed));
                rate_drop_p2_in <= b;
                n += b;
                @(posedge clk_in);
            end
            // a drop beside the read lands after the value is taken
            rate_drop_p2_in <= 1'b1;
            fork
                reg_read(`ADDR_RATE_DROP_CNT, got);
                begin
                    @(posedge clk_in);
                    rate_drop_p2_in <= 1'b0;
                end
            join
            check("count", got, n);
            reg_read(`ADDR_RATE_DROP_CNT, got);
            check("count after read", got, 32'h0000_0001);
            reg_read(`ADDR_RATE_DROP_CNT, got);
            check("count cleared", got, 32'h0000_0000);
        end
        reg_write(`ADDR_DROP_INT_MASK, 32'hffff_ffff);
        reg_read(`ADDR_DROP_INT_MASK, got);
        check("mask readback", got, 32'h0000_0001);
        drop_event(`RSN_RED, `PORT_TWO);
        drop_valid_in <= 1'b0;
        irq_check(1'b0);
        reg_write(`ADDR_DROP_INT_MASK, 32'h0000_0000);
        irq_check(1'b1);
        reg_read(`ADDR_DROP_INT_PEND, got);
        check("masked capture", got, pend_exp());
        slot_a = 7'h00;
        irq_check(1'b0);
        for (int r = 0; r < 16; r++) begin
            p = 2'($random(seed));
            drop_event(4'(r), p);
            drop_event(legal[3'($random(seed))], 2'($random(seed)));
            drop_event(4'(r), `PORT_ONE);
            drop_valid_in <= 1'b0;
            irq_check(slot_a[0] | slot_b[0]);
            reg_read(`ADDR_DROP_INT_PEND, got);
            check("pending", got, pend_exp());
            check("slot b", 32'(got[13:7]), 32'(slot_b));
            check("slot a", 32'(got[6:0]), 32'(slot_a));
            slot_a = 7'h00;
            slot_b = 7'h00;
            reg_read(`ADDR_DROP_INT_PEND, got);
            check("pending cleared", got, 32'h0000_0000);
        end
        // side status: clear, enable the count bit, then one drop
        reg_write(`ADDR_IRQ_CLR, 32'h0000_0007);
        reg_read(`ADDR_IRQ_STAT, got);
        check("status cleared", got, 32'h0000_0000);
        reg_write(`ADDR_IRQ_EN, 32'h0000_0001);
        reg_read(`ADDR_IRQ_EN, got);
        check("enable readback", got, 32'h0000_0001);
        irq_check(1'b0);
        rate_drop_p2_in <= 1'b1;
        @(posedge clk_in);
        rate_drop_p2_in <= 1'b0;
        irq_check(1'b1);
        reg_read(`ADDR_IRQ_STAT, got);
        check("status count", got, 32'h0000_0001);
        reg_write(`ADDR_DROP_INT_MASK, 32'h0000_0001);
        irq_check(1'b0);
        // a drop in the cycle of the clear keeps the bit set
        rate_drop_p2_in <= 1'b1;
        fork
            reg_write(`ADDR_IRQ_CLR, 32'h0000_0001);
            begin
                @(posedge clk_in);
                rate_drop_p2_in <= 1'b0;
            end
        join
        reg_read(`ADDR_IRQ_STAT, got);
        check("status set wins", got, 32'h0000_0001);
        reg_write(`ADDR_IRQ_CLR, 32'h0000_0001);
        reg_read(`ADDR_IRQ_STAT, got);
        check("status clear", got, 32'h0000_0000);
        wrap_up();
    end
endmodule
`default_nettype wire
